// [cdcfg_consts.vh]
// What this block does
// - byte 5 bit 7 is chip enable, resets 1; zero forces quiescent state.
// - byte 5 bits 6..0 enable output pairs 10..4; reset 1; zero disables.
// - byte 6 bits 7..4 enable output pairs 3..0; reset 1; zero disables.
// - byte 6 bits 3..0 loop bandwidth select, reset 0; set bits mean external filter.
// - byte 7 bit 7 is PLL enable, resets 1; zero switches PLL off.
// - byte 7 bits 5..4 input pre-divider: 1, 2, 4 or 8; default 1.
// - byte 7 bits 3..0 feedback divider: 1000 gives 32, 1001 gives 40 (default).
// - post-divider codes 0000..1010 give 1,2,4,5,8,10,16,20,32,40,80; default 20.
// - ratio 5 ignores the phase field and gives zero lead.
// - ratios 10, 20, 40 and 80 ignore phase bit 0; upper bits count k steps of 2pi/(ratio/5).
// - phase bits above those the ratio uses are don't-care.
// - group post-divider enable zero disables all five outputs of the group.
// - outputs gated by PLL lock unless lock override is set.
// - bandwidth 0000 keeps on-chip filter on; listed codes switch it off.
`ifndef CDCFG_CONSTS_VH
`define CDCFG_CONSTS_VH
// ----------------------------------------
// register offsets and reset values
// ----------------------------------------
`define CDCFG_OFS_OUT_HI    3'h5
`define CDCFG_OFS_OUT_LO_BW 3'h6
`define CDCFG_OFS_PLL_DIV   3'h7
`define CDCFG_RST_OUT_HI    8'hFF
`define CDCFG_RST_OUT_LO_BW 8'hF0
`define CDCFG_RST_PLL_DIV   8'h89
`define CDCFG_PLL_DIV_MASK  8'hBF
// ----------------------------------------
// field positions
// ----------------------------------------
`define CDCFG_CHIP_EN_BIT   7
`define CDCFG_PLL_EN_BIT    7
`define CDCFG_FB_DIV_32     4'h8
`define CDCFG_FB_DIV_40     4'h9
`define CDCFG_POST_MAX      4'hA
`endif

// [cdcfg_phase_decode.v]
`timescale 1ns/1ns
`default_nettype none
`include "cdcfg_consts.vh"
module cdcfg_phase_decode (
   // post-divider selection and phase field
   input  wire [3:0] post_div_select,
   input  wire [4:0] phase,
   // decoded ratio and lead
   output reg  [6:0] ratio,
   output reg  [3:0] lead_steps,
   output reg  [4:0] steps_per_cycle,
   output reg        code_valid
);
   always @* begin
      ratio           = 7'h01;
      lead_steps      = 4'h0;
      steps_per_cycle = 5'h01;
      code_valid      = 1'b1;
      case (post_div_select)
         4'h0: ratio = 7'h01;
         4'h1: ratio = 7'h02;
         4'h2: ratio = 7'h04;
         4'h3: ratio = 7'h05;
         4'h4: ratio = 7'h08;
         4'h5: begin
            ratio = 7'h0A;
            lead_steps = {3'h0, phase[1]};
            steps_per_cycle = 5'h02;
         end
         4'h6: ratio = 7'h10;
         4'h7: begin
            ratio = 7'h14;
            lead_steps = {2'h0, phase[2:1]};
            steps_per_cycle = 5'h04;
         end
         4'h8: ratio = 7'h20;
         4'h9: begin
            ratio = 7'h28;
            lead_steps = {1'b0, phase[3:1]};
            steps_per_cycle = 5'h08;
         end
         4'hA: begin
            ratio = 7'h50;
            lead_steps = phase[4:1];
            steps_per_cycle = 5'h10;
         end
         default: code_valid = 1'b0;
      endcase
   end
endmodule
`default_nettype wire

// [cdcfg_top.v]
`timescale 1ns/1ns
`default_nettype none
`include "cdcfg_consts.vh"
module cdcfg_top (
   // clock and reset
   input  wire        mclk,
   input  wire        sys_rst,
   // register port from the serial management engine
   input  wire [2:0]  reg_addr,
   input  wire        reg_wr,
   input  wire [7:0]  reg_wdata,
   output reg  [7:0]  reg_rdata,
   // fields held in other bytes
   input  wire [3:0]  group_a_post_div_select,
   input  wire [3:0]  group_b_post_div_select,
   input  wire [4:0]  group_a_phase,
   input  wire [4:0]  group_b_phase,
   input  wire        group_a_active,
   input  wire        group_b_active,
   input  wire        lock_gate_override,
   input  wire        pll_locked,
   // controls toward the analog blocks
   output reg  [10:0] drv_on,
   output reg         quiescent,
   output reg         pll_power_on,
   output reg  [3:0]  input_div_ratio,
   output reg  [5:0]  feedback_div_ratio,
   output reg         feedback_code_valid,
   output reg  [3:0]  loop_bandwidth_select,
   output reg         ext_loop_filter,
   output reg         onchip_filter_on,
   output reg  [6:0]  group_a_ratio,
   output reg  [6:0]  group_b_ratio,
   output reg  [3:0]  group_a_lead,
   output reg  [3:0]  group_b_lead,
   output reg  [4:0]  group_a_steps,
   output reg  [4:0]  group_b_steps,
   output reg  [1:0]  post_code_valid
);
   // ----------------------------------------
   // configuration bytes
   // ----------------------------------------
   reg  [7:0] output_enable_high;
   reg  [7:0] output_enable_low_bandwidth;
   reg  [7:0] pll_divider_control;
   always @(posedge mclk) begin
      if (sys_rst) begin
         output_enable_high          <= `CDCFG_RST_OUT_HI;
         output_enable_low_bandwidth <= `CDCFG_RST_OUT_LO_BW;
         pll_divider_control         <= `CDCFG_RST_PLL_DIV;
      end else if (reg_wr) begin
         case (reg_addr)
            `CDCFG_OFS_OUT_HI:    output_enable_high <= reg_wdata;
            `CDCFG_OFS_OUT_LO_BW: output_enable_low_bandwidth <= reg_wdata;
            // reserved bit 6 stays zero
            `CDCFG_OFS_PLL_DIV:   pll_divider_control <= reg_wdata & `CDCFG_PLL_DIV_MASK;
            default: ;
         endcase
      end
   end
   // unmapped bytes read zero; other bytes are served outside this block
   always @* begin
      case (reg_addr)
         `CDCFG_OFS_OUT_HI:    reg_rdata = output_enable_high;
         `CDCFG_OFS_OUT_LO_BW: reg_rdata = output_enable_low_bandwidth;
         `CDCFG_OFS_PLL_DIV:   reg_rdata = pll_divider_control;
         default:              reg_rdata = 8'h00;
      endcase
   end
   // ----------------------------------------
   // post-divider decode per group
   // ----------------------------------------
   wire [6:0] a_ratio;
   wire [6:0] b_ratio;
   wire [3:0] a_lead;
   wire [3:0] b_lead;
   wire [4:0] a_steps;
   wire [4:0] b_steps;
   wire       a_ok;
   wire       b_ok;
   cdcfg_phase_decode u_dec_a (
      .post_div_select (group_a_post_div_select),
      .phase           (group_a_phase),
      .ratio           (a_ratio),
      .lead_steps      (a_lead),
      .steps_per_cycle (a_steps),
      .code_valid      (a_ok)
   );
   cdcfg_phase_decode u_dec_b (
      .post_div_select (group_b_post_div_select),
      .phase           (group_b_phase),
      .ratio           (b_ratio),
      .lead_steps      (b_lead),
      .steps_per_cycle (b_steps),
      .code_valid      (b_ok)
   );
   // ----------------------------------------
   // registered controls
   // ----------------------------------------
   wire        chip_on  = output_enable_high[`CDCFG_CHIP_EN_BIT];
   wire        pll_on   = pll_divider_control[`CDCFG_PLL_EN_BIT];
   // lock gating holds even with the pll off; the override or pll_locked lifts it
   wire        lock_ok  = lock_gate_override | pll_locked;
   wire [10:0] raw_en   = {output_enable_high[6:0], output_enable_low_bandwidth[7:4]};
   wire [10:0] grp_en   = {1'b1, {5{group_b_active}}, {5{group_a_active}}};
   wire [3:0]  bw       = output_enable_low_bandwidth[3:0];
   reg  [3:0]  next_in_div;
   reg  [5:0]  next_fb_div;
   reg         next_fb_ok;
   always @* begin
      case (pll_divider_control[5:4])
         2'h0:    next_in_div = 4'h1;
         2'h1:    next_in_div = 4'h2;
         2'h2:    next_in_div = 4'h4;
         default: next_in_div = 4'h8;
      endcase
      next_fb_ok = 1'b1;
      case (pll_divider_control[3:0])
         `CDCFG_FB_DIV_32: next_fb_div = 6'h20;
         `CDCFG_FB_DIV_40: next_fb_div = 6'h28;
         default: begin
            // undefined code: hold the default ratio and flag it
            next_fb_div = 6'h28;
            next_fb_ok  = 1'b0;
         end
      endcase
   end
   always @(posedge mclk) begin
      if (sys_rst) begin
         drv_on                <= 11'h000;
         quiescent             <= 1'b0;
         pll_power_on          <= 1'b1;
         input_div_ratio       <= 4'h1;
         feedback_div_ratio    <= 6'h28;
         feedback_code_valid   <= 1'b1;
         loop_bandwidth_select <= 4'h0;
         ext_loop_filter       <= 1'b0;
         onchip_filter_on      <= 1'b1;
         group_a_ratio         <= 7'h14;
         group_b_ratio         <= 7'h14;
         group_a_lead          <= 4'h0;
         group_b_lead          <= 4'h0;
         group_a_steps         <= 5'h04;
         group_b_steps         <= 5'h04;
         post_code_valid       <= 2'h3;
      end else begin
         quiescent             <= ~chip_on;
         drv_on                <= (chip_on & lock_ok) ? (raw_en & grp_en) : 11'h000;
         pll_power_on          <= pll_on & chip_on;
         input_div_ratio       <= next_in_div;
         feedback_div_ratio    <= next_fb_div;
         feedback_code_valid   <= next_fb_ok;
         loop_bandwidth_select <= bw;
         ext_loop_filter       <= |bw;
         onchip_filter_on      <= (bw == 4'h0);
         group_a_ratio         <= a_ratio;
         group_b_ratio         <= b_ratio;
         group_a_lead          <= a_lead;
         group_b_lead          <= b_lead;
         group_a_steps         <= a_steps;
         group_b_steps         <= b_steps;
         post_code_valid       <= {b_ok, a_ok};
      end
   end
endmodule
`default_nettype wire

// [cdcfg_chk.sv]
`timescale 1ns/1ns
`default_nettype none
module cdcfg_chk (
   // clock and register port
   input wire logic        mclk,
   input wire logic        sys_rst,
   input wire logic [2:0]  reg_addr,
   input wire logic        reg_wr,
   input wire logic [7:0]  reg_wdata,
   // external levels
   input wire logic        pll_locked,
   input wire logic        lock_gate_override,
   input wire logic        group_a_active,
   input wire logic [3:0]  group_b_post_div_select,
   // decoded controls
   input wire logic [10:0] drv_on,
   input wire logic        quiescent,
   input wire logic        pll_power_on,
   input wire logic [3:0]  input_div_ratio,
   input wire logic [3:0]  loop_bandwidth_select,
   input wire logic        ext_loop_filter,
   input wire logic        onchip_filter_on,
   input wire logic [6:0]  group_b_ratio,
   input wire logic [3:0]  group_b_lead
);
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);
   chip_off_a: assert property (quiescent |-> drv_on == 11'h000 && !pll_power_on)
      else $error("chip off left drivers or pll on");
   quiet_map_a: assert property (reg_wr && reg_addr == 3'h5 |-> ##2 quiescent == !$past(reg_wdata[7], 2))
      else $error("quiescent does not follow chip enable");
   pll_off_a: assert property (reg_wr && reg_addr == 3'h7 && !reg_wdata[7] |-> ##2 !pll_power_on)
      else $error("pll left on");
   in_div_a: assert property (reg_wr && reg_addr == 3'h7 |-> ##2 input_div_ratio == 4'h1 << $past(reg_wdata[5:4], 2))
      else $error("input divider wrong");
   lock_gate_a: assert property (!$past(lock_gate_override) && !$past(pll_locked) |-> drv_on == 11'h000)
      else $error("drivers on without lock");
   group_gate_a: assert property (!$past(group_a_active) |-> drv_on[4:0] == 5'h00)
      else $error("group a drivers on while group off");
   bw_filter_a: assert property (onchip_filter_on == (loop_bandwidth_select == 4'h0) && ext_loop_filter == (loop_bandwidth_select != 4'h0))
      else $error("loop filter select wrong");
   ratio_five_a: assert property ((group_b_post_div_select == 4'h3) [*3] |-> group_b_ratio == 7'h05 && group_b_lead == 4'h0)
      else $error("ratio five lead not zero");
   cover property (reg_wr && reg_addr == 3'h5 && !reg_wdata[7]);
   cover property (lock_gate_override && !pll_locked && drv_on != 11'h000);
   cover property (group_b_ratio == 7'h50);
endmodule
bind cdcfg_top cdcfg_chk chk_i (.*);
`default_nettype wire

// [cdcfg_host.sv]
`timescale 1ns/1ns
`default_nettype none
module cdcfg_host (
   // clock and read-back
   input  wire logic       mclk,
   input  wire logic [7:0] reg_rdata,
   // register port toward the device
   output var  logic [2:0] reg_addr,
   output var  logic       reg_wr,
   output var  logic [7:0] reg_wdata
);
   initial begin
      reg_addr = 3'h0;
      reg_wr = 1'b0;
      reg_wdata = 8'h00;
   end
   // only listed divider codes are ever sent
   task automatic write_byte(input logic [2:0] a, input logic [7:0] d);
      @(negedge mclk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge mclk);
      reg_wr = 1'b0;
      // released data is inverted so no stale value looks valid
      reg_wdata = ~d;
   endtask
   task automatic read_byte(input logic [2:0] a, output logic [7:0] d);
      @(negedge mclk);
      reg_addr = a;
      // read data is taken at the rising edge while the address stands
      @(posedge mclk);
      d = reg_rdata;
   endtask
endmodule
`default_nettype wire

// [tb_top.sv]
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   logic        mclk, sys_rst, reg_wr, pll_locked, lock_gate_override, group_a_active, group_b_active;
   logic        quiescent, pll_power_on, feedback_code_valid, ext_loop_filter, onchip_filter_on;
   logic [2:0]  reg_addr;
   logic [7:0]  reg_wdata, reg_rdata, rd;
   logic [3:0]  group_a_post_div_select, group_b_post_div_select, input_div_ratio, b;
   logic [3:0]  loop_bandwidth_select, group_a_lead, group_b_lead;
   logic [4:0]  group_a_phase, group_b_phase, group_a_steps, group_b_steps;
   logic [5:0]  feedback_div_ratio;
   logic [6:0]  group_a_ratio, group_b_ratio;
   logic [10:0] drv_on;
   logic [1:0]  post_code_valid;
   int          n_mismatch, compares, cycles;
   logic [7:0]  rst_val [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hF0, 8'h89};
   logic [3:0]  bw_codes [6] = '{4'h0, 4'h2, 4'h3, 4'h4, 4'h6, 4'h8};
   // row: select, phase, ratio, lead, steps
   logic [24:0] rows [12] = '{{4'h0, 5'h1F, 7'h01, 4'h0, 5'h01}, {4'h1, 5'h1F, 7'h02, 4'h0, 5'h01},
      {4'h2, 5'h1F, 7'h04, 4'h0, 5'h01}, {4'h3, 5'h1F, 7'h05, 4'h0, 5'h01}, {4'h4, 5'h1F, 7'h08, 4'h0, 5'h01},
      {4'h5, 5'h1E, 7'h0A, 4'h1, 5'h02}, {4'h6, 5'h1F, 7'h10, 4'h0, 5'h01}, {4'h7, 5'h1B, 7'h14, 4'h1, 5'h04},
      {4'h8, 5'h1F, 7'h20, 4'h0, 5'h01}, {4'h9, 5'h0E, 7'h28, 4'h7, 5'h08}, {4'hA, 5'h11, 7'h50, 4'h8, 5'h10},
      {4'hB, 5'h1F, 7'h01, 4'h0, 5'h01}};
   cdcfg_top dut (.*);
   cdcfg_host host (.*);
   initial mclk = 1'b0;
   always #10 mclk = ~mclk;
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic settle;
      repeat (3) @(negedge mclk);
   endtask
   task automatic finish_test;
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 3000) begin
         n_mismatch++;
         finish_test;
      end
   end
   initial begin
      {sys_rst, pll_locked, group_a_active, group_b_active, lock_gate_override} = 5'h1E;
      {group_a_post_div_select, group_b_post_div_select, group_a_phase, group_b_phase} = 18'h1DC00;
      repeat (5) @(negedge mclk);
      sys_rst = 1'b0;
      for (int i = 0; i < 12; i++) begin
         {group_a_post_div_select, group_a_phase} = rows[i][24:16];
         {group_b_post_div_select, group_b_phase} = rows[i][24:16] ^ 9'h001;
         settle;
         chk("ratio", {2{rows[i][15:9]}}, {group_a_ratio, group_b_ratio});
         chk("lead a", rows[i][8:5], group_a_lead);
         chk("lead b", rows[i][8:5], group_b_lead);
         chk("steps", {2{rows[i][4:0]}}, {group_a_steps, group_b_steps});
         chk("code valid", {2{i < 11}}, post_code_valid);
      end
      $display("test rows done");
      for (int a = 0; a < 8; a++) begin
         host.read_byte(a[2:0], rd);
         chk("reset byte", rst_val[a], rd);
      end
      chk("reset ctl", {2'h2, 4'h1, 6'h28, 1'b1, 1'b1, 11'h7FF}, {pll_power_on, quiescent, input_div_ratio,
         feedback_div_ratio, feedback_code_valid, onchip_filter_on, drv_on});
      $display("test reset done");
      host.write_byte(3'h5, 8'hAA);
      host.write_byte(3'h6, 8'h50);
      settle;
      chk("drv map", 11'h2A5, drv_on);
      group_a_active = 1'b0;
      settle;
      chk("group off", 11'h2A0, drv_on);
      group_a_active = 1'b1;
      pll_locked = 1'b0;
      settle;
      chk("unlocked", 11'h000, drv_on);
      lock_gate_override = 1'b1;
      settle;
      chk("override", 11'h2A5, drv_on);
      host.write_byte(3'h5, 8'h7F);
      settle;
      chk("chip off", 3'h4, {quiescent, pll_power_on, |drv_on});
      host.write_byte(3'h5, 8'hFF);
      $display("test drivers done");
      for (int m = 0; m < 4; m++) begin
         host.write_byte(3'h7, {2'h3, m[1:0], 4'h8});
         host.read_byte(3'h7, rd);
         settle;
         chk("byte7", {2'h2, m[1:0], 4'h8}, rd);
         chk("dividers", {4'h1 << m, 6'h20, 1'b1}, {input_div_ratio, feedback_div_ratio, feedback_code_valid});
      end
      host.write_byte(3'h7, 8'h09);
      settle;
      chk("pll off", {1'b0, 6'h28, 1'b1}, {pll_power_on, feedback_div_ratio, feedback_code_valid});
      $display("test dividers done");
      foreach (bw_codes[j]) begin
         b = bw_codes[j];
         host.write_byte(3'h6, {4'hF, b});
         settle;
         chk("bandwidth", {b, b != 4'h0, b == 4'h0}, {loop_bandwidth_select, ext_loop_filter, onchip_filter_on});
      end
      host.write_byte(3'h2, 8'h5A);
      host.read_byte(3'h2, rd);
      chk("unmapped", 8'h00, rd);
      $display("test bandwidth done");
      // second reset in mid-run: bytes 6 and 7 hold non-default values here
      @(negedge mclk);
      sys_rst = 1'b1;
      repeat (2) @(negedge mclk);
      chk("in reset", 13'h0800, {quiescent, pll_power_on, drv_on});
      sys_rst = 1'b0;
      for (int a = 5; a < 8; a++) begin
         host.read_byte(a[2:0], rd);
         chk("reset again", rst_val[a], rd);
      end
      settle;
      chk("after reset", 13'h0FFF, {quiescent, pll_power_on, drv_on});
      $display("test mid reset done");
      finish_test;
   end
endmodule
`default_nettype wire
